// ===== delay_timer.sv
// Purpose: millisecond-scaled turn-on and turn-off delay for one level
// Assumes: delays in units of one tick
// Notes:   output follows input after the matching delay
`timescale 1ns/1ps
module delay_timer #(
	parameter int unsigned tick_cycles = 25000
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        level_in,
	input  wire logic [15:0] on_ticks,
	input  wire logic [15:0] off_ticks,
	output logic             level_out
);
	typedef struct packed {
		logic [15:0] ticks;
		logic [31:0] pre;
		logic        out;
	} st_t;
	st_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		if (level_in == s_q.out) begin
			s_d.ticks = 16'h0000;
			s_d.pre   = 32'h0;
		end else if ((level_in ? on_ticks : off_ticks) == s_q.ticks) begin
			s_d.out = level_in;
		end else if (s_q.pre == 32'(tick_cycles - 1)) begin
			s_d.pre   = 32'h0;
			s_d.ticks = s_q.ticks + 16'h0001;
		end else begin
			s_d.pre = s_q.pre + 32'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign level_out = s_q.out;
endmodule

// ===== output_terminal.sv
// Purpose: multi-function output terminal selection, inversion and timing
// Assumes: drive status inputs synchronous to pclk except brake feedback pin
// Notes:   registers on APB, one aligned word each
`timescale 1ns/1ps
import output_terminal_pkg::*;
// How it works
// - codes 20-23 follow warning, over-voltage, current stall, voltage stall
// - code 24 on while run command source is nonzero
// - code 25 on forward, 26 on reverse direction
// - code 27 current at or above threshold, 28 below
// - code 29 frequency at or above signed boundary, 30 below
// - code 33 running with zero output frequency
// - code 34 zero output frequency or stopped
// - codes 35-38 follow fault output options one to four
// - code 40 speed attained; 31,32,39,41 drive nothing
// - 16-bit inversion mask, low 12 bits one per terminal, reset zero
// - serial start picks run commands (0) or enable input (1)
// - codes 3 and 4 on when desired frequency 1 or 2 attained
// - code 12 on after running for brake release delay
// - code 12 off after stopped for brake engage delay
// - code 15 on; drive output starts after contactor on delay
// - code 15 released after contactor off delay once output stops
// - brake feedback absent past detection time raises fault 64
module output_terminal #(
	parameter int unsigned ms_cycles = output_terminal_pkg::cycles_per_ms
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                run_active,
	input  wire logic                forward_reverse_commands,
	input  wire logic                enable_input,
	input  wire logic                dir_reverse,
	input  wire logic                warn_any,
	input  wire logic                warn_over_voltage,
	input  wire logic                warn_oc_stall,
	input  wire logic                warn_ov_stall,
	input  wire logic [6:0]          out_current_pct,
	input  wire logic signed [15:0]  out_freq,
	input  wire logic [15:0]         freq_setting,
	input  wire logic [3:0]          fault_option,
	input  wire logic                brake_feedback,
	output logic                     relay_a,
	output logic                     relay_b,
	output logic      [9:0]          transistor_out,
	output logic                     drive_output_enable,
	output logic                     brake_feedback_fault,
	output logic      [6:0]          fault_code
);
	import output_terminal_pkg::*;

	// ==========================================
	// state
	typedef struct packed {
		logic [11:0][5:0] sel;
		logic [15:0]      mask;
		logic [6:0]       cur_th;
		logic [15:0]      fbound;
		logic [15:0]      dfreq1;
		logic [15:0]      dwidth1;
		logic [15:0]      dfreq2;
		logic [15:0]      dwidth2;
		logic [15:0]      brk_rel;
		logic [15:0]      brk_eng;
		logic [15:0]      con_on;
		logic [15:0]      con_off;
		logic [9:0]       brk_det;
		logic             serial_start;
		logic [1:0]       run_src;
		logic [2:0]       fb_sync;
		logic             fb_level;
		logic [31:0]      det_cnt;
		logic             fault;
		logic [6:0]       fcode;
		logic [11:0]      term;
		logic             out_en;
		logic [31:0]      rdata;
		logic             ready;
	} st_t;
	st_t s_q, s_d;

	// ==========================================
	// condition decode
	logic        brake_timed;
	logic        con_timed;
	logic        start_req;
	logic [63:0] cond;

	function automatic logic attained(input logic [15:0] f, input logic [15:0] tgt,
			input logic [15:0] w);
		logic [16:0] af;
		af = out_freq[15] ? 17'(-out_freq) : 17'(out_freq);
		attained = (af + 17'(w) >= 17'(tgt)) && (af <= 17'(tgt) + 17'(w));
	endfunction

	// one select word per terminal, four bytes apart
	function automatic logic sel_hit(input logic [7:0] addr, input int idx);
		sel_hit = (addr == off_select_base + 8'(4 * idx));
	endfunction


	assign start_req = s_q.serial_start ? enable_input : forward_reverse_commands;

	always_comb begin
		cond     = 64'h0;
		cond[3]  = attained(16'(out_freq), s_q.dfreq1, s_q.dwidth1);
		cond[4]  = attained(16'(out_freq), s_q.dfreq2, s_q.dwidth2);
		cond[12] = brake_timed;
		cond[15] = con_timed;
		cond[20] = warn_any;
		cond[21] = warn_over_voltage;
		cond[22] = warn_oc_stall;
		cond[23] = warn_ov_stall;
		cond[24] = s_q.run_src != 2'b00;
		cond[25] = run_active && !dir_reverse;
		cond[26] = run_active && dir_reverse;
		cond[27] = out_current_pct >= s_q.cur_th;
		cond[28] = out_current_pct < s_q.cur_th;
		cond[29] = out_freq >= $signed(s_q.fbound);
		cond[30] = out_freq < $signed(s_q.fbound);
		cond[33] = run_active && out_freq == 16'sh0000;
		cond[34] = !run_active || out_freq == 16'sh0000;
		cond[38:35] = fault_option;
		cond[40] = (out_freq[15] ? 16'(-out_freq) : 16'(out_freq)) == freq_setting;
	end

	// ==========================================
	// terminal selection and inversion
	logic [11:0] term_d;
	for (genvar g = 0; g < terminal_count; g++) begin : g_term
		assign term_d[g] = cond[s_q.sel[g]] ^ s_q.mask[g];
	end

	// ==========================================
	// brake and contactor timing
	delay_timer #(.tick_cycles(ms_cycles)) u_brake (
		.pclk      (pclk),
		.presetn   (presetn),
		.level_in  (run_active),
		.on_ticks  (s_q.brk_rel),
		.off_ticks (s_q.brk_eng),
		.level_out (brake_timed)
	);

	logic con_ready;
	delay_timer #(.tick_cycles(ms_cycles)) u_contactor (
		.pclk      (pclk),
		.presetn   (presetn),
		.level_in  (start_req),
		.on_ticks  (s_q.con_on),
		.off_ticks (s_q.con_off),
		.level_out (con_ready)
	);
	// contactor closes at once on start, opens after the off delay
	assign con_timed = start_req || con_ready;

	// ==========================================
	// register access and next state
	always_comb begin
		logic [7:0] a;
		logic       wr;
		logic       set_fault;
		a = paddr;
		wr = psel && penable && pwrite && !s_q.ready;
		set_fault = 1'b0;
		s_d = s_q;
		s_d.ready = psel && penable && !s_q.ready;

		// ==========================================
		// brake feedback pin, three flops
		s_d.fb_sync = {s_q.fb_sync[1:0], brake_feedback};
		if (s_q.fb_sync[2] == s_q.fb_sync[1]) begin
			s_d.fb_level = s_q.fb_sync[2];
		end
		// brake feedback supervision while release is commanded
		if (!brake_timed || s_q.fb_level) begin
			s_d.det_cnt = 32'h0;
		end else if (s_q.det_cnt < 32'(s_q.brk_det) * 32'(ms_cycles * 10)) begin
			s_d.det_cnt = s_q.det_cnt + 32'h1;
		end else begin
			set_fault = 1'b1;
		end

		// ==========================================
		// contactor gate and terminals
		s_d.out_en = start_req && con_ready;
		s_d.term = term_d;

		// ==========================================
		// read word captured in the setup phase
		s_d.rdata = 32'h0;
		if (psel && !penable) begin
			if (a == off_invert_mask) begin
				s_d.rdata = {16'h0, s_q.mask};
			end
			for (int i = 0; i < terminal_count; i++) begin
				if (sel_hit(a, i)) begin
					s_d.rdata = {26'h0, s_q.sel[i]};
				end
			end
			case (a)
				off_cur_thresh:  s_d.rdata = {25'h0, s_q.cur_th};
				off_freq_bound:  s_d.rdata = {16'h0, s_q.fbound};
				off_des_freq_1:  s_d.rdata = {16'h0, s_q.dfreq1};
				off_des_width_1: s_d.rdata = {16'h0, s_q.dwidth1};
				off_des_freq_2:  s_d.rdata = {16'h0, s_q.dfreq2};
				off_des_width_2: s_d.rdata = {16'h0, s_q.dwidth2};
				off_brk_release: s_d.rdata = {16'h0, s_q.brk_rel};
				off_brk_engage:  s_d.rdata = {16'h0, s_q.brk_eng};
				off_con_on:      s_d.rdata = {16'h0, s_q.con_on};
				off_con_off:     s_d.rdata = {16'h0, s_q.con_off};
				off_brk_detect:  s_d.rdata = {22'h0, s_q.brk_det};
				off_control:     s_d.rdata = {26'h0, s_q.run_src, 3'h0, s_q.serial_start};
				off_status:      s_d.rdata = {19'h0, s_q.fault, s_q.term};
				default:         s_d.rdata = s_d.rdata;
			endcase
		end else if ((psel && penable) || s_q.ready) begin
			// hold the setup-phase word through the access phase
			s_d.rdata = s_q.rdata;
		end

		// ==========================================
		// register writes
		if (wr) begin
			if (a == off_invert_mask) begin
				s_d.mask = pwdata[15:0];
			end
			for (int i = 0; i < terminal_count; i++) begin
				if (sel_hit(a, i)) begin
					s_d.sel[i] = pwdata[5:0];
				end
			end
			case (a)
				off_cur_thresh: begin
					s_d.cur_th = pwdata[6:0];
					if (pwdata[6:0] > 7'h64) s_d.cur_th = 7'h64;
				end
				off_freq_bound:  s_d.fbound = pwdata[15:0];
				off_des_freq_1:  s_d.dfreq1 = pwdata[15:0];
				off_des_width_1: s_d.dwidth1 = pwdata[15:0];
				off_des_freq_2:  s_d.dfreq2 = pwdata[15:0];
				off_des_width_2: s_d.dwidth2 = pwdata[15:0];
				off_brk_release: s_d.brk_rel = pwdata[15:0];
				off_brk_engage:  s_d.brk_eng = pwdata[15:0];
				off_con_on:      s_d.con_on = pwdata[15:0];
				off_con_off:     s_d.con_off = pwdata[15:0];
				off_brk_detect: begin
					s_d.brk_det = pwdata[9:0];
					if (pwdata[9:0] > 10'h3e8) s_d.brk_det = 10'h3e8;
				end
				off_control: begin
					s_d.serial_start = pwdata[ctl_serial_start_bit];
					s_d.run_src = pwdata[ctl_run_source_lsb +: 2];
				end
				off_status:      s_d.fault = s_d.fault & ~pwdata[12];
				default:         s_d.mask = s_d.mask;
			endcase
		end
		// a clear in the same cycle as a new fault loses
		if (set_fault) begin
			s_d.fault = 1'b1;
		end
		s_d.fcode = s_d.fault ? fault_code_brake : 7'h00;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q         <= '0;
			s_q.mask    <= rst_invert_mask;
			s_q.cur_th  <= rst_cur_thresh;
			s_q.fbound  <= rst_freq_bound;
			s_q.dfreq1  <= rst_des_freq;
			s_q.dwidth1 <= rst_des_width;
			s_q.dfreq2  <= rst_des_freq;
			s_q.dwidth2 <= rst_des_width;
			s_q.brk_rel <= rst_brk_delay;
			s_q.brk_eng <= rst_brk_delay;
			s_q.con_on  <= rst_con_delay;
			s_q.con_off <= rst_con_delay;
			s_q.brk_det <= rst_brk_detect;
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// outputs
	assign prdata               = s_q.rdata;
	assign pready               = s_q.ready;
	assign pslverr              = 1'b0;
	assign relay_a              = s_q.term[0];
	assign relay_b              = s_q.term[1];
	assign transistor_out       = s_q.term[11:2];
	assign drive_output_enable  = s_q.out_en;
	assign brake_feedback_fault = s_q.fault;
	assign fault_code           = s_q.fcode;
endmodule

// ===== output_terminal_chk.sv
// Purpose: port assertions for the output terminal logic
// Assumes: apb write lands at the first access edge
// Notes:   terminal 0 code and mask bit 0 are mirrored here
`timescale 1ns/1ps
module output_terminal_chk (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        run_active,
	input wire logic        warn_any,
	input wire logic signed [15:0] out_freq,
	input wire logic        relay_a,
	input wire logic        brake_feedback_fault,
	input wire logic [6:0]  fault_code
);
	import output_terminal_pkg::*;
	// ====================
	// register mirror
	logic       wr;
	logic [5:0] sel0_q;
	logic       inv0_q;
	assign wr = psel && penable && pwrite && !pready;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel0_q <= 6'h00;
			inv0_q <= 1'b0;
		end else if (wr) begin
			if (paddr == off_select_base)
				sel0_q <= pwdata[5:0];
			if (paddr == off_invert_mask)
				inv0_q <= pwdata[0];
		end
	end
	// ====================
	// properties
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_held(logic [5:0] code, logic c);
		(sel0_q == code && c)[*4];
	endsequence
	sequence s_access;
		psel && penable && !pready;
	endsequence
	chk_pready_wait: assert property (s_access |=> pready)
		else $error("pready missing after access");
	chk_pready_pulse: assert property (pready |=> !pready)
		else $error("pready held too long");
	chk_fault_code: assert property (
		fault_code == (brake_feedback_fault ? fault_code_brake : 7'h00))
		else $error("fault code does not match fault flag");
	chk_fault_hold: assert property (
		brake_feedback_fault && !(wr && paddr == off_status && pwdata[12])
		|=> brake_feedback_fault)
		else $error("fault flag dropped without clear");
	chk_warn_follow: assert property (s_held(6'd20, warn_any && !inv0_q) |-> relay_a)
		else $error("relay_a not following warning");
	chk_warn_invert: assert property (s_held(6'd20, warn_any && inv0_q) |-> !relay_a)
		else $error("relay_a not inverted");
	chk_zero_stop: assert property (s_held(6'd34, !run_active && !inv0_q) |-> relay_a)
		else $error("relay_a off while stopped");
	chk_zero_moving: assert property (
		s_held(6'd34, run_active && out_freq != 0 && !inv0_q) |-> !relay_a)
		else $error("relay_a on while moving");
endmodule
bind output_terminal output_terminal_chk output_terminal_chk_i (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pready, .run_active, .warn_any, .out_freq,
	.relay_a, .brake_feedback_fault, .fault_code);

// ===== output_terminal_pkg.sv
// Purpose: constants for the output terminal logic
// Assumes: 25 MHz pclk, APB register access
// Notes:   time counts are derived from ms figures
package output_terminal_pkg;
	localparam int unsigned clk_hz         = 25000000;
	localparam int unsigned cycles_per_ms  = clk_hz / 1000;
	localparam int unsigned cycles_per_10ms = clk_hz / 100;
	localparam int          terminal_count = 12;
	// register byte offsets
	localparam logic [7:0] off_invert_mask = 8'h00;
	localparam logic [7:0] off_select_base = 8'h04; // 12 words, one per terminal
	localparam logic [7:0] off_cur_thresh  = 8'h34;
	localparam logic [7:0] off_freq_bound  = 8'h38;
	localparam logic [7:0] off_des_freq_1  = 8'h3c;
	localparam logic [7:0] off_des_width_1 = 8'h40;
	localparam logic [7:0] off_des_freq_2  = 8'h44;
	localparam logic [7:0] off_des_width_2 = 8'h48;
	localparam logic [7:0] off_brk_release = 8'h4c;
	localparam logic [7:0] off_brk_engage  = 8'h50;
	localparam logic [7:0] off_con_on      = 8'h54;
	localparam logic [7:0] off_con_off     = 8'h58;
	localparam logic [7:0] off_brk_detect  = 8'h5c;
	localparam logic [7:0] off_control     = 8'h60;
	localparam logic [7:0] off_status      = 8'h64;
	// reset values
	localparam logic [15:0] rst_invert_mask = 16'h0000;
	localparam logic [6:0]  rst_cur_thresh  = 7'h00;
	localparam logic [15:0] rst_freq_bound  = 16'h0000;
	localparam logic [15:0] rst_des_freq    = 16'h1770;
	localparam logic [15:0] rst_des_width   = 16'h00c8;
	localparam logic [15:0] rst_brk_delay   = 16'h00fa;
	localparam logic [15:0] rst_con_delay   = 16'h00c8;
	localparam logic [9:0]  rst_brk_detect  = 10'h000;
	// control register fields
	localparam int ctl_serial_start_bit = 0;
	localparam int ctl_run_source_lsb   = 4;
	// selection codes and brake fault code
	localparam logic [5:0] sel_des_freq_1  = 6'h03;
	localparam logic [5:0] sel_des_freq_2  = 6'h04;
	localparam logic [5:0] sel_brake       = 6'h0c;
	localparam logic [5:0] sel_contactor   = 6'h0f;
	localparam logic [5:0] fault_mech_brake = 6'h3f; // fault code 64 reported as 7 bits
	localparam logic [6:0] fault_code_brake = 7'h40;
endpackage

// ===== relay_model.sv
// Purpose: brake coil with feedback switch behind the brake terminal
// Assumes: feedback closes lag cycles after the coil is energised
// Notes:   stuck holds the switch open like a seized brake
`timescale 1ns/1ps
module relay_model #(
	parameter int lag = 3
) (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic brake_coil,
	input  wire logic stuck,
	output logic      brake_feedback
);
	logic [7:0] coil_q;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			coil_q <= 8'h00;
		else
			coil_q <= {coil_q[6:0], brake_coil};
	end
	assign brake_feedback = coil_q[lag - 1] && !stuck;
endmodule

// ===== tb_top.sv
// Purpose: self-checking bench for the output terminal logic
// Assumes: ms tick shortened to 4 cycles
// Notes:   terminals compared as one 12-bit vector
`timescale 1ns/1ps
`define CHK(a, e) begin \
	comparisons++; \
	if ((a) !== (e)) begin \
		failures++; \
		$display("FAIL t=%0t got %h exp %h", $time, (a), (e)); \
	end \
end
module tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        run_active = 1'b0;
	logic        forward_reverse_commands = 1'b0;
	logic        enable_input = 1'b0;
	logic        dir_reverse = 1'b0;
	logic [3:0]  warn = 4'h0;
	logic [6:0]  out_current_pct = 7'h00;
	logic [15:0] out_freq = 16'h0;
	logic [15:0] freq_setting = 16'h0;
	logic [3:0]  fault_option = 4'h0;
	logic        stuck = 1'b0;
	logic        brake_feedback;
	logic        relay_a;
	logic        relay_b;
	logic [9:0]  transistor_out;
	logic        drive_output_enable;
	logic        brake_feedback_fault;
	logic [6:0]  fault_code;
	logic [31:0] r;
	int          failures = 0;
	int          comparisons = 0;
	logic [7:0]  ra [10] = '{8'h00, 8'h34, 8'h38, 8'h3c, 8'h40, 8'h4c, 8'h50, 8'h54,
		8'h58, 8'h5c};
	logic [15:0] rv [10] = '{16'h0, 16'h0, 16'h0, 16'h1770, 16'hc8, 16'hfa, 16'hfa,
		16'hc8, 16'hc8, 16'h0};
	logic [5:0]  cd [12] = '{6'd34, 6'd25, 6'd26, 6'd27, 6'd28, 6'd29, 6'd30, 6'd33,
		6'd31, 6'd40, 6'd24, 6'd3};
	wire  [13:0] mon = {brake_feedback_fault, drive_output_enable, transistor_out,
		relay_b, relay_a};
	output_terminal #(.ms_cycles(4)) output_terminal_i (.pclk, .presetn, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .run_active,
		.forward_reverse_commands, .enable_input, .dir_reverse, .warn_any(warn[0]),
		.warn_over_voltage(warn[1]), .warn_oc_stall(warn[2]), .warn_ov_stall(warn[3]),
		.out_current_pct, .out_freq, .freq_setting, .fault_option, .brake_feedback,
		.relay_a, .relay_b, .transistor_out, .drive_output_enable,
		.brake_feedback_fault, .fault_code);
	relay_model #(.lag(3)) relay_model_i (.pclk, .presetn, .brake_coil(relay_a), .stuck,
		.brake_feedback);
	initial begin
		forever #20 pclk = ~pclk;
	end
	// ====================
	// shared tasks
	task automatic finish_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			`CHK(pready, 1'b1)
			finish_test;
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		apb(1'b1, a, d, q);
	endtask
	task automatic wait_bit(input int b, input logic v, input int lim);
		int n;
		n = 0;
		while (mon[b] !== v && n < lim) begin
			@(posedge pclk);
			n++;
		end
		if (n >= lim) begin
			`CHK(mon[b], v)
			finish_test;
		end
	endtask
	task automatic st(input logic ra_, input logic d, input logic [6:0] c,
		input logic [15:0] f, input logic [15:0] s);
		@(posedge pclk);
		run_active <= ra_;
		dir_reverse <= d;
		out_current_pct <= c;
		out_freq <= f;
		freq_setting <= s;
		wt(4);
	endtask
	// ====================
	// scenarios
	initial begin
		wt(8);
		presetn <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			apb(1'b0, ra[i], 32'h0, r);
			`CHK(r[15:0], rv[i])
		end
		wr(8'h80, 32'h5a);
		apb(1'b0, 8'h80, 32'h0, r);
		`CHK(r, 32'h0)
		$display("test reset done");
		for (int c = 0; c < 4; c++) begin
			wr(8'h04, 32'(20 + c));
			wr(8'h08, 32'(35 + c));
			for (int k = 0; k < 4; k++) begin
				warn <= 4'(1 << k);
				fault_option <= 4'(1 << k);
				wt(4);
				`CHK(relay_a, 1'(k == c))
				`CHK(relay_b, 1'(k == c))
			end
		end
		wr(8'h04, 32'd20);
		warn <= 4'h1;
		wr(8'h00, 32'h1);
		wt(3);
		`CHK(relay_a, 1'b0)
		wr(8'h00, 32'h0);
		$display("test warnings done");
		for (int i = 0; i < 12; i++)
			wr(8'(4 + 4 * i), 32'(cd[i]));
		wr(8'h34, 32'd50);
		wr(8'h38, 32'hff9c);
		wr(8'h3c, 32'd1000);
		wr(8'h40, 32'd200);
		st(1, 0, 50, -16'sd100, 100);
		`CHK(mon[11:0], 12'h22a)
		wr(8'h60, 32'h10);
		st(1, 1, 49, 0, 0);
		`CHK(mon[11:0], 12'h6b5)
		st(1, 0, 49, 1150, 0);
		`CHK(mon[11:0], 12'hc32)
		wr(8'h00, 32'h801);
		wt(3);
		`CHK(mon[11:0], 12'h433)
		wr(8'h00, 32'h0);
		st(0, 0, 49, 500, 0);
		`CHK(relay_a, 1'b1)
		$display("test selection done");
		wr(8'h04, 32'd12);
		wr(8'h08, 32'd15);
		wr(8'h4c, 32'd5);
		wr(8'h50, 32'd3);
		wr(8'h54, 32'd2);
		wr(8'h58, 32'd4);
		wr(8'h5c, 32'd2);
		wr(8'h60, 32'h0);
		run_active <= 1'b1;
		wt(14);
		`CHK(relay_a, 1'b0)
		wait_bit(0, 1'b1, 16);
		wt(100);
		`CHK(brake_feedback_fault, 1'b0)
		run_active <= 1'b0;
		wt(6);
		`CHK(relay_a, 1'b1)
		wait_bit(0, 1'b0, 16);
		forward_reverse_commands <= 1'b1;
		wait_bit(1, 1'b1, 4);
		`CHK(drive_output_enable, 1'b0)
		wait_bit(12, 1'b1, 16);
		forward_reverse_commands <= 1'b0;
		wt(8);
		`CHK(relay_b, 1'b1)
		wait_bit(1, 1'b0, 24);
		wr(8'h60, 32'h1);
		forward_reverse_commands <= 1'b1;
		wt(6);
		`CHK(relay_b, 1'b0)
		enable_input <= 1'b1;
		wait_bit(1, 1'b1, 4);
		forward_reverse_commands <= 1'b0;
		enable_input <= 1'b0;
		wait_bit(1, 1'b0, 24);
		$display("test timing done");
		stuck <= 1'b1;
		run_active <= 1'b1;
		wait_bit(0, 1'b1, 30);
		wt(40);
		`CHK(brake_feedback_fault, 1'b0)
		wait_bit(13, 1'b1, 120);
		`CHK(fault_code, 7'h40)
		run_active <= 1'b0;
		stuck <= 1'b0;
		wait_bit(0, 1'b0, 24);
		wr(8'h64, 32'h1000);
		wt(2);
		`CHK(brake_feedback_fault, 1'b0)
		$display("test brake fault done");
		finish_test;
	end
endmodule
